//--- hdl/zcb_defines.vh
// constants for the compare-with-zero branch unit: field positions, opcodes, widths
// assumes a 32-bit instruction word and 64-bit general registers
`ifndef ZCB_DEFINES_VH
`define ZCB_DEFINES_VH
`define ZCB_OP_HI        31
`define ZCB_OP_LO        26
`define ZCB_RS_HI        25
`define ZCB_RS_LO        21
`define ZCB_RT_HI        20
`define ZCB_RT_LO        16
`define ZCB_OFF_HI       15
`define ZCB_OFF_LO       0
`define ZCB_OP_POS       6'h07
`define ZCB_OP_POS_L     6'h17
`define ZCB_OP_NONPOS    6'h06
`define ZCB_OP_NONPOS_L  6'h16
`define ZCB_OP_REGISTER_IMMEDIATE_MAJOR_OPCODE    6'h01
`define ZCB_SUB_NEG      5'h00
`define ZCB_SUB_NEG_LNK  5'h10
`define ZCB_SUB_NEG_LNKL 5'h12
`define ZCB_RT_ZERO      5'h00
`define ZCB_LINK_REG     5'h1F
`define ZCB_LINK_OFS     64'h0000000000000008
`define ZCB_SLOT_OFS     64'h0000000000000004
`define ZCB_GPR_W        64
`define ZCB_RST_BIT      1'b0
`define ZCB_RST_REG      5'h00
`define ZCB_RST_WORD     64'h0000000000000000
`endif

//--- hdl/zcb_decode.v
// combinational decoder for the compare-with-zero branch family
// assumes the instruction word and source value are stable within the step
`include "zcb_defines.vh"
module zcb_decode (
    input  wire [31:0] i_instr,     // instruction word
    input  wire [63:0] i_src,       // source register value
    output reg         o_hit,       // one of the family
    output reg         o_cond,      // condition true
    output reg         o_likely,    // likely form
    output reg         o_link,      // link form
    output wire [63:0] o_disp       // sign-extended displacement
);
    wire [5:0]  op  = i_instr[`ZCB_OP_HI:`ZCB_OP_LO];
    wire [4:0]  rt  = i_instr[`ZCB_RT_HI:`ZCB_RT_LO];
    wire [15:0] off = i_instr[`ZCB_OFF_HI:`ZCB_OFF_LO];
    // full width sign and zero test
    wire neg  = i_src[`ZCB_GPR_W-1];
    wire zero = (i_src == 64'h0000000000000000);

    assign o_disp = {{46{off[15]}}, off, 2'h0};

    // opcode decode and condition select
    always @* begin
        o_hit    = 1'b0;
        o_cond   = 1'b0;
        o_likely = 1'b0;
        o_link   = 1'b0;
        case (op)
            `ZCB_OP_POS, `ZCB_OP_POS_L: begin
                o_hit    = (rt == `ZCB_RT_ZERO);
                o_likely = (op == `ZCB_OP_POS_L);
                o_cond   = !neg && !zero;
            end
            `ZCB_OP_NONPOS, `ZCB_OP_NONPOS_L: begin
                o_hit    = (rt == `ZCB_RT_ZERO);
                o_likely = (op == `ZCB_OP_NONPOS_L);
                o_cond   = neg || zero;
            end
            `ZCB_OP_REGISTER_IMMEDIATE_MAJOR_OPCODE: begin
                o_cond = neg;
                case (rt)
                    `ZCB_SUB_NEG: o_hit = 1'b1;
                    `ZCB_SUB_NEG_LNK: begin
                        o_hit  = 1'b1;
                        o_link = 1'b1;
                    end
                    `ZCB_SUB_NEG_LNKL: begin
                        o_hit    = 1'b1;
                        o_link   = 1'b1;
                        o_likely = 1'b1;
                    end
                    default: o_hit = 1'b0;
                endcase
            end
            default: o_hit = 1'b0;
        endcase
    end
endmodule // zcb_decode

//--- hdl/zcb_unit.v
// branch resolve unit: one instruction step per valid fetch beat
// assumes the pipeline presents one instruction per step with its address,
// reads the source register combinationally, and obeys the delay-slot limits
`include "zcb_defines.vh"
module zcb_unit (
    input  wire        I_CLK,          // 100 MHz clock
    input  wire        I_RST_N,        // synchronous reset, active low
    input  wire        I_VALID,        // instruction step present
    input  wire [31:0] I_INSTR,        // instruction word
    input  wire [63:0] I_PC,           // address of this instruction
    input  wire [63:0] I_SRC_DATA,     // value of source register
    output reg  [4:0]  O_SRC_ADDR,     // source register select (registered)
    output reg         O_LINK_WE,      // link write strobe
    output reg  [4:0]  O_LINK_ADDR,    // link destination
    output reg  [63:0] O_LINK_DATA,    // return address
    output reg         O_PC_WE,        // redirect strobe
    output reg  [63:0] O_PC_TARGET,    // redirect target
    output reg         O_NULLIFY,      // squash current slot
    output reg         O_BR_SEEN       // branch step taken in
);
    // decoder sees the live word; rs select output is registered and lags it by one step
    wire        hit;
    wire        cond;
    wire        likely;
    wire        link;
    wire [63:0] disp;

    zcb_decode u_dec (
        .i_instr  (I_INSTR),
        .i_src    (I_SRC_DATA),
        .o_hit    (hit),
        .o_cond   (cond),
        .o_likely (likely),
        .o_link   (link),
        .o_disp   (disp)
    );

    // step timing, seen from the fetch side:
    //   edge a: family branch sampled; condition and target formed
    //   edge a+1: link, squash and step flag stand one cycle
    //   edge b: next step with I_VALID high is the slot
    //   edge b+1: redirect strobe and target stand one cycle
    // bubbles between a and b only stretch the wait
    // redirect is registered: one cycle late, but every output is a flop

    // limitations for the user:
    //   no stall input; a stalled slot is held with I_VALID low
    //   source value must belong to the branch step itself,
    //   so any bypass from an older write settles before this unit
    //   the slot word is decoded here only to tell a branch from a slot; the pipeline squashes it
    //   from O_NULLIFY in the cycle after the branch
    //   no exception is raised for any decoded word

    // slot tracker codes: a taken branch parks in wait until its slot
    localparam [0:0] ST_IDLE = 1'b0;        // no redirect outstanding
    localparam [0:0] ST_WAIT = 1'b1;        // taken branch, slot not yet seen

    // registered state and the next values that feed it
    reg        state;                       // slot tracker
    reg        next_state;                  // slot tracker, next
    reg [63:0] pend_target;                 // target held across the slot
    reg [63:0] next_pend_target;            // held target, next
    reg [4:0]  next_src_addr;               // source select, next
    reg        next_link_we;                // link strobe, next
    reg [4:0]  next_link_addr;              // link destination, next
    reg [63:0] next_link_data;              // return address, next
    reg        next_pc_we;                  // redirect strobe, next
    reg [63:0] next_pc_target;              // redirect target, next
    reg        next_nullify;                // slot squash, next
    reg        next_br_seen;                // branch flag, next

    // step classes; a step without I_VALID is a bubble
    wire        br_step       = I_VALID && hit;     // family branch now
    wire        slot_step     = I_VALID && !hit;    // any other real step
    wire        taken         = br_step && cond;    // condition true now
    // a branch in a slot is undefined by software contract, so it is not
    // guarded: the latest branch simply replaces whatever was pending

    wire [63:0] branch_target = I_PC + `ZCB_SLOT_OFS + disp;
    wire [63:0] link_value    = I_PC + `ZCB_LINK_OFS;

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (taken) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (br_step) begin
                    // a second branch overrides; its own outcome decides
                    next_state = cond ? ST_WAIT : ST_IDLE;
                end else if (slot_step) begin
                    // slot has executed, so the redirect goes out now
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // target captured at every family branch; used only while waiting
    always @* begin
        next_pend_target = pend_target;
        if (br_step) begin
            next_pend_target = branch_target;
        end
    end

    // link regardless of outcome
    // address and data hold between strobes, so a late reader still
    // sees the last return address
    always @* begin
        next_link_we   = 1'b0;
        next_link_addr = O_LINK_ADDR;
        next_link_data = O_LINK_DATA;
        if (br_step && link) begin
            next_link_we   = 1'b1;
            next_link_addr = `ZCB_LINK_REG;
            next_link_data = link_value;
        end
    end

    // redirect once slot executed
    // target holds after the strobe; only the strobe means anything
    always @* begin
        next_pc_we     = 1'b0;
        next_pc_target = O_PC_TARGET;
        if (slot_step && (state == ST_WAIT)) begin
            next_pc_we     = 1'b1;
            next_pc_target = pend_target;
        end
    end

    always @* begin
        next_nullify = br_step && likely && !cond;
    end

    // step flag, one pulse per family branch
    always @* begin
        next_br_seen = br_step;
    end

    // source select; informational, one step late
    always @* begin
        next_src_addr = I_INSTR[`ZCB_RS_HI:`ZCB_RS_LO];
    end

    // slot tracker registers; reset drops any redirect still pending
    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state       <= ST_IDLE;
            pend_target <= `ZCB_RST_WORD;
        end else begin
            state       <= next_state;
            pend_target <= next_pend_target;
        end
    end

    // link write port registers
    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_LINK_WE   <= `ZCB_RST_BIT;
            O_LINK_ADDR <= `ZCB_RST_REG;
            O_LINK_DATA <= `ZCB_RST_WORD;
        end else begin
            O_LINK_WE   <= next_link_we;
            O_LINK_ADDR <= next_link_addr;
            O_LINK_DATA <= next_link_data;
        end
    end

    // redirect port registers
    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_PC_WE     <= `ZCB_RST_BIT;
            O_PC_TARGET <= `ZCB_RST_WORD;
        end else begin
            O_PC_WE     <= next_pc_we;
            O_PC_TARGET <= next_pc_target;
        end
    end

    // squash and step flag registers
    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_NULLIFY <= `ZCB_RST_BIT;
            O_BR_SEEN <= `ZCB_RST_BIT;
        end else begin
            O_NULLIFY <= next_nullify;
            O_BR_SEEN <= next_br_seen;
        end
    end

    // source select register
    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_SRC_ADDR <= `ZCB_RST_REG;
        end else begin
            O_SRC_ADDR <= next_src_addr;
        end
    end
endmodule // zcb_unit

//--- tb/zcb_props.sv
// assertions for zcb_unit, bound to every instance
// assumes a slot step follows each branch and holds no branch
module zcb_props (
    input wire logic        I_CLK, I_RST_N, I_VALID, // clock, reset, step
    input wire logic [31:0] I_INSTR,                 // word
    input wire logic [63:0] I_PC, I_SRC_DATA,        // address, source
    input wire logic        O_LINK_WE, O_PC_WE, O_NULLIFY, O_BR_SEEN, // strobes
    input wire logic [4:0]  O_LINK_ADDR,             // link register
    input wire logic [63:0] O_LINK_DATA, O_PC_TARGET // link, target
);
    timeunit 1ns;
    timeprecision 100ps;
    // own decode, so a slip shared with the design cannot hide
    wire [5:0]  op  = I_INSTR[31:26];
    wire [4:0]  rt  = I_INSTR[20:16];
    wire        rim = op == 6'h01;
    wire        lnk = rim && (rt == 5'h10 || rt == 5'h12);
    wire        lkl = (rt == 5'h00 && op[5:1] == 5'h0B) || (rim && rt == 5'h12);
    wire        nrm = rt == 5'h00 && (op[5:1] == 5'h03 || op[5:1] == 5'h0B);
    wire        hit = I_VALID && (nrm || lnk || (rim && rt == 5'h00));
    wire        sgn = I_SRC_DATA[63];
    wire        zro = I_SRC_DATA == 64'h0;
    wire        cnd = rim ? sgn : op[0] ? !sgn && !zro : sgn || zro;
    wire [63:0] tgt = I_PC + 64'h4 + {{46{I_INSTR[15]}}, I_INSTR[15:0], 2'h0};
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    a_link_write: assert property (hit && lnk |=> O_LINK_WE && O_LINK_ADDR == 5'h1F
        && O_LINK_DATA == $past(I_PC) + 64'h8) else $error("link write wrong");
    a_link_none: assert property (!(hit && lnk) |=> !O_LINK_WE)
        else $error("link strobe without link branch");
    a_seen_hit: assert property (hit |=> O_BR_SEEN)
        else $error("branch step not flagged");
    a_seen_none: assert property (!hit |=> !O_BR_SEEN)
        else $error("flag without family branch");
    a_slot_squash: assert property (hit && lkl && !cnd |=> O_NULLIFY)
        else $error("slot not squashed");
    a_slot_runs: assert property (hit && !(lkl && !cnd) |=> !O_NULLIFY)
        else $error("slot squashed wrongly");
    a_redirect_taken: assert property (hit && cnd ##1 I_VALID |=> O_PC_WE
        && O_PC_TARGET == $past(tgt, 2)) else $error("redirect missing or wrong");
    a_redirect_none: assert property (hit && !cnd ##1 I_VALID |=> !O_PC_WE)
        else $error("redirect on false condition");
endmodule // zcb_props
bind zcb_unit zcb_props zcb_props_i (.I_CLK, .I_RST_N, .I_VALID, .I_INSTR, .I_PC,
    .I_SRC_DATA, .O_LINK_WE, .O_PC_WE, .O_NULLIFY, .O_BR_SEEN, .O_LINK_ADDR,
    .O_LINK_DATA, .O_PC_TARGET);

//--- tb/tb.sv
// bench for zcb_unit: branch table, then gap and reset cases
// assumes zcb_props is bound from its own file
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin mismatches++; \
    $display("wrong value at %0t: got %h", $time, g); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        I_CLK = 0, I_RST_N = 0, I_VALID = 0;
    logic [31:0] I_INSTR = 32'h0;
    logic [63:0] I_PC = 64'h0, I_SRC_DATA = 64'h0, pc, off;
    logic        O_LINK_WE, O_PC_WE, O_NULLIFY, O_BR_SEEN;
    logic [4:0]  O_SRC_ADDR, O_LINK_ADDR;
    logic [63:0] O_LINK_DATA, O_PC_TARGET;
    int          mismatches = 0, cmp_count = 0;
    // word, source, expected {link, squash, redirect, flag}
    // link rows name r1, never r31
    typedef struct {logic [31:0] w; logic [63:0] s; logic [3:0] e;} zcb_row_t;
    zcb_row_t rows [13] = '{'{32'h1C20FFFF, 64'h10000000000, 4'h3},
        '{32'h1C20FFFF, 64'h0, 4'h1}, '{32'h1C21FFFF, 64'h5, 4'h0},
        '{32'h5C207FFF, 64'h8000000000000000, 4'h5}, '{32'h5C207FFF, 64'h3, 4'h3},
        '{32'h18208000, 64'h0, 4'h3}, '{32'h18208000, 64'h1, 4'h1},
        '{32'h58200010, 64'h2, 4'h5}, '{32'h04200004, 64'h8000000000000000, 4'h3},
        '{32'h04300004, 64'h1, 4'h9}, '{32'h04320004, 64'h1, 4'hD},
        '{32'h04320004, 64'hFFFFFFFFFFFFFFFF, 4'hB}, '{32'h04210004, 64'hFFFFFFFFFFFFFFFF, 4'h0}};
    zcb_unit zcb_unit_i (
        .I_CLK       (I_CLK),
        .I_RST_N     (I_RST_N),
        .I_VALID     (I_VALID),
        .I_INSTR     (I_INSTR),
        .I_PC        (I_PC),
        .I_SRC_DATA  (I_SRC_DATA),
        .O_SRC_ADDR  (O_SRC_ADDR),
        .O_LINK_WE   (O_LINK_WE),
        .O_LINK_ADDR (O_LINK_ADDR),
        .O_LINK_DATA (O_LINK_DATA),
        .O_PC_WE     (O_PC_WE),
        .O_PC_TARGET (O_PC_TARGET),
        .O_NULLIFY   (O_NULLIFY),
        .O_BR_SEEN   (O_BR_SEEN)
    );
    // free-running 100 MHz clock
    initial forever #5 I_CLK = ~I_CLK;
    task print_verdict;
        if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // one step, launched just after a rising edge
    task drive(input logic v, input logic [31:0] w, input logic [63:0] p, s);
        @(posedge I_CLK);
        I_VALID <= v;
        I_INSTR <= w;
        I_PC <= p;
        I_SRC_DATA <= s;
    endtask
    // hang guard, far beyond the ~55 cycles the run needs
    initial begin
        repeat (1000) @(posedge I_CLK);
        mismatches++;
        print_verdict();
    end
    // table of branches, each followed by its slot, then awkward cases
    initial begin
        repeat (6) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        #1 `CHK({O_LINK_WE, O_PC_WE, O_NULLIFY, O_BR_SEEN}, 4'h0)
        for (int i = 0; i < 13; i++) begin
            pc = 64'h4000 + 64'(i) * 64'h100;
            off = {{46{rows[i].w[15]}}, rows[i].w[15:0], 2'h0};
            drive(1'b1, rows[i].w, pc, rows[i].s);
            drive(1'b1, 32'h0, pc + 64'h4, ~rows[i].s);
            #1 `CHK({O_LINK_WE, O_NULLIFY, O_BR_SEEN}, {rows[i].e[3:2], rows[i].e[0]})
            if (rows[i].e[3]) `CHK(O_LINK_DATA, pc + 64'h8)
            if (rows[i].e[3]) `CHK(O_LINK_ADDR, 5'h1F)
            `CHK(O_SRC_ADDR, rows[i].w[25:21])
            drive(1'b0, 32'h0, pc, 64'h0);
            #1 `CHK(O_PC_WE, rows[i].e[1])
            if (rows[i].e[1]) `CHK(O_PC_TARGET, pc + 64'h4 + off)
        end
        // idle gap between branch and slot: redirect waits for the slot
        drive(1'b1, 32'h04200010, 64'h8000, 64'hFFFFFFFFFFFFFFFF);
        drive(1'b0, 32'h0, 64'h0, 64'h0);
        drive(1'b0, 32'h0, 64'h0, 64'h0);
        #1 `CHK(O_PC_WE, 1'b0)
        drive(1'b1, 32'h0, 64'h8004, 64'h0);
        drive(1'b0, 32'h0, 64'h0, 64'h0);
        #1 `CHK({O_PC_WE, O_PC_TARGET}, {1'b1, 64'h8044})
        // reset between branch and slot drops the pending redirect
        drive(1'b1, 32'h04200010, 64'h8000, 64'hFFFFFFFFFFFFFFFF);
        drive(1'b0, 32'h0, 64'h0, 64'h0);
        I_RST_N <= 1'b0;
        drive(1'b1, 32'h0, 64'h8004, 64'h0);
        I_RST_N <= 1'b1;
        #1 `CHK({O_LINK_WE, O_PC_WE, O_NULLIFY, O_BR_SEEN}, 4'h0)
        drive(1'b0, 32'h0, 64'h0, 64'h0);
        #1 `CHK(O_PC_WE, 1'b0)
        print_verdict();
    end
endmodule // tb
